/* File: include/asc_cfg.svh */
// Offsets, field positions, reset values and timing counts of the slot configuration bank
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

`define ASC_ADDR_A_TIMING   8'h39
`define ASC_ADDR_B_TIMING   8'h3B
`define ASC_ADDR_A_MODE     8'h42
`define ASC_ADDR_A_PATH     8'h43
`define ASC_ADDR_B_MODE     8'h44
`define ASC_ADDR_GAIN_PWR   8'h55
`define ASC_ADDR_DIG_EN     8'h58
`define ASC_ADDR_DIG_OPT    8'h5A

`define ASC_RST_TIMING      16'h22FC
`define ASC_RST_MODE        16'h1C38
`define ASC_RST_PATH        16'hADA5
`define ASC_RST_ZERO        16'h0000

`define ASC_MASK_GAIN_PWR   16'hEFFF
`define ASC_MASK_DIG_EN     16'h3000
`define ASC_MASK_DIG_OPT    16'h00E0

`define ASC_CODE_FULL       16'hADA5
`define ASC_CODE_TIA_BUF    16'hAE65
`define ASC_CODE_TIA_NOBUF  16'hB065
`define ASC_MODE_NORMAL     8'h1C
`define ASC_MODE_DIGINT     8'h1D
`define ASC_PD_ALL          3'h7

`define ASC_F_WIDTH         15:11
`define ASC_F_COARSE        10:5
`define ASC_F_FINE          4:0
`define ASC_F_MODE          15:8
`define ASC_B_BUF           7
`define ASC_B_IND_EN        6
`define ASC_F_COMMON_GAIN   1:0
`define ASC_F_PD            15:13
`define ASC_F_GAIN_B        11:6
`define ASC_F_GAIN_A        5:0
`define ASC_B_DIG_EN_B      13
`define ASC_B_DIG_EN_A      12
`define ASC_B_GAP           7
`define ASC_B_PAIR_B        6
`define ASC_B_PAIR_A        5

`define ASC_CLK_NS          50
`define ASC_STEP_US_NS      1000
`define ASC_CYC_PER_US      (`ASC_STEP_US_NS / `ASC_CLK_NS)

`endif

/* File: include/asc_pkg.sv */
// Types shared by the slot configuration bank
package asc_pkg;

	typedef enum logic [2:0]
	{
		ASC_PATH_FULL    = 3'b001,
		ASC_PATH_TIA_ADC = 3'b010,
		ASC_PATH_RSVD    = 3'b100
	} asc_path_t;

	typedef enum logic [2:0]
	{
		ASC_FE_NORMAL = 3'b001,
		ASC_FE_DIGINT = 3'b010,
		ASC_FE_RSVD   = 3'b100
	} asc_fe_mode_t;

	typedef enum logic [1:0]
	{
		ASC_GAIN_200K = 2'h0,
		ASC_GAIN_100K = 2'h1,
		ASC_GAIN_50K  = 2'h2,
		ASC_GAIN_25K  = 2'h3
	} asc_gain_t;

endpackage : asc_pkg

/* File: include/asc_gain_if.sv */
// Gain selection signals passed between the bank and its gain resolver
`timescale 1ns/1ps
interface asc_gain_if;
	logic       ind_en;
	logic [1:0] common;
	logic [5:0] upper;
	logic [7:0] gain;

	modport src (output ind_en, output common, output upper, input gain);
	modport sel (input ind_en, input common, input upper, output gain);
endinterface : asc_gain_if

/* File: verilog/asc_gain_sel.sv */
// Per-channel gain resolver for one time slot
`timescale 1ns/1ps
module asc_gain_sel
(
	asc_gain_if.sel g
);
	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_ch
			if (i == 0)
			begin : g_first
				assign g.gain[1:0] = g.common;
			end
			else
			begin : g_upper
				assign g.gain[2*i+1:2*i] = g.ind_en ? g.upper[2*i-1:2*i-2] : g.common;
			end
		end
	endgenerate
endmodule : asc_gain_sel

/* File: verilog/asc_slot_regs.sv */
// Slot configuration register bank with decoded front-end controls
// Behaviour
// - Slot A path code ADA5 full path; AE65 with buffer, B065 without, converter mode.
// - Power field 0 keeps channels up; 7 powers down channels 2-4 in integration.
// - Slot B channels 4,3,2 gains in own two-bit fields, 200k to 25k.
// - Slot A channels 4,3,2 gains in own two-bit fields, same encoding.
// - Gap bit 0 gives no gap; 1 uses each slot fine offset as gap.
// - Pair mode bit 0 double-sample, 1 single-sample, per slot.
// - Slot B window width five bits in 1 us steps, resets to 4.
// - Slot B coarse offset six bits in 1 us steps, resets to 0x17.
// - Slot B fine offset five bits in 31.25 ns steps, resets to 0x1C.
// - Slot B mode byte 0x1C normal chain, 0x1D digital integrate.
// - Slot B buffer bit converts integrator; digital integrate mode forces it.
// - Slot B individual enable: channel 1 from mode bits, 2-4 from shared register.
// - Individual gains off: common field sets all channels; on: channel 1 only.
// - Digital integration enabled per slot by bits 13 and 12.
`timescale 1ns/1ps
`include "asc_cfg.svh"
module asc_slot_regs
(
	input  wire logic        CLK,
	input  wire logic        RST_N,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic        REG_WE,
	input  wire logic        REG_RE,
	output logic      [15:0] REG_RDATA,
	output logic             REG_RVALID,
	output logic      [2:0]  SLOTA_PATH,
	output logic      [2:0]  SLOTB_MODE,
	output logic             SLOTA_INT_BUF,
	output logic             SLOTB_INT_BUF,
	output logic      [7:0]  SLOTA_GAIN,
	output logic      [7:0]  SLOTB_GAIN,
	output logic             SLOTA_DIGINT_EN,
	output logic             SLOTB_DIGINT_EN,
	output logic             SLOTA_UPPER_PD,
	output logic             SLOTB_UPPER_PD,
	output logic      [4:0]  SLOTA_GAP_US,
	output logic      [4:0]  SLOTB_GAP_US,
	output logic             SLOTA_SINGLE_PAIR,
	output logic             SLOTB_SINGLE_PAIR,
	output logic      [9:0]  SLOTB_WIDTH_CYC,
	output logic      [10:0] SLOTB_OFFSET_CYC,
	output logic      [4:0]  SLOTB_FINE_OFFSET
);
	localparam logic [4:0] CYC_PER_US = 5'(`ASC_CYC_PER_US);

	logic [15:0] timing_a_q;
	logic [15:0] timing_b_q;
	logic [15:0] mode_a_q;
	logic [15:0] path_a_q;
	logic [15:0] mode_b_q;
	logic [15:0] gain_pwr_q;
	logic [15:0] dig_en_q;
	logic [15:0] dig_opt_q;
	logic [15:0] rdata_q;
	logic        rvalid_q;

	// Address decode
	wire sel_timing_a = (REG_ADDR == `ASC_ADDR_A_TIMING);
	wire sel_timing_b = (REG_ADDR == `ASC_ADDR_B_TIMING);
	wire sel_mode_a   = (REG_ADDR == `ASC_ADDR_A_MODE);
	wire sel_path_a   = (REG_ADDR == `ASC_ADDR_A_PATH);
	wire sel_mode_b   = (REG_ADDR == `ASC_ADDR_B_MODE);
	wire sel_gain_pwr = (REG_ADDR == `ASC_ADDR_GAIN_PWR);
	wire sel_dig_en   = (REG_ADDR == `ASC_ADDR_DIG_EN);
	wire sel_dig_opt  = (REG_ADDR == `ASC_ADDR_DIG_OPT);

	// Read selection, unmapped addresses read zero
	wire [15:0] rd_mux = ({16{sel_timing_a}} & timing_a_q)
		| ({16{sel_timing_b}} & timing_b_q)
		| ({16{sel_mode_a}} & mode_a_q)
		| ({16{sel_path_a}} & path_a_q)
		| ({16{sel_mode_b}} & mode_b_q)
		| ({16{sel_gain_pwr}} & gain_pwr_q)
		| ({16{sel_dig_en}} & dig_en_q)
		| ({16{sel_dig_opt}} & dig_opt_q);

	// Register storage; reserved bits are held at zero in the gain/power, enable and option registers only
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			timing_a_q <= `ASC_RST_TIMING;
			timing_b_q <= `ASC_RST_TIMING;
			mode_a_q   <= `ASC_RST_MODE;
			path_a_q   <= `ASC_RST_PATH;
			mode_b_q   <= `ASC_RST_MODE;
			gain_pwr_q <= `ASC_RST_ZERO;
			dig_en_q   <= `ASC_RST_ZERO;
			dig_opt_q  <= `ASC_RST_ZERO;
		end
		else if (REG_WE)
		begin
			if (sel_timing_a) timing_a_q <= REG_WDATA;
			if (sel_timing_b) timing_b_q <= REG_WDATA;
			if (sel_mode_a)   mode_a_q   <= REG_WDATA;
			if (sel_path_a)   path_a_q   <= REG_WDATA;
			if (sel_mode_b)   mode_b_q   <= REG_WDATA;
			if (sel_gain_pwr) gain_pwr_q <= REG_WDATA & `ASC_MASK_GAIN_PWR;
			if (sel_dig_en)   dig_en_q   <= REG_WDATA & `ASC_MASK_DIG_EN;
			if (sel_dig_opt)  dig_opt_q  <= REG_WDATA & `ASC_MASK_DIG_OPT;
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= REG_RE;
			if (REG_RE)
				rdata_q <= rd_mux;
		end
	end

	assign REG_RDATA  = rdata_q;
	assign REG_RVALID = rvalid_q;

	// Front-end decode
	wire mode_a_digint = (mode_a_q[`ASC_F_MODE] == `ASC_MODE_DIGINT);
	wire mode_b_digint = (mode_b_q[`ASC_F_MODE] == `ASC_MODE_DIGINT);
	wire mode_b_normal = (mode_b_q[`ASC_F_MODE] == `ASC_MODE_NORMAL);
	wire buf_a         = mode_a_q[`ASC_B_BUF] | mode_a_digint;
	wire buf_b         = mode_b_q[`ASC_B_BUF] | mode_b_digint;
	wire path_full     = (path_a_q == `ASC_CODE_FULL);
	wire path_tia      = ((path_a_q == `ASC_CODE_TIA_BUF) & mode_a_q[`ASC_B_BUF])
		| ((path_a_q == `ASC_CODE_TIA_NOBUF) & ~mode_a_q[`ASC_B_BUF])
		| ((path_a_q == `ASC_CODE_TIA_BUF) & mode_a_digint);
	wire dig_a         = dig_en_q[`ASC_B_DIG_EN_A];
	wire dig_b         = dig_en_q[`ASC_B_DIG_EN_B];
	wire pd_all        = (gain_pwr_q[`ASC_F_PD] == `ASC_PD_ALL);
	wire gap_en        = dig_opt_q[`ASC_B_GAP];

	wire asc_pkg::asc_path_t path_a_w = path_full ? asc_pkg::ASC_PATH_FULL
		: (path_tia ? asc_pkg::ASC_PATH_TIA_ADC : asc_pkg::ASC_PATH_RSVD);
	wire asc_pkg::asc_fe_mode_t fe_b_w = mode_b_normal ? asc_pkg::ASC_FE_NORMAL
		: (mode_b_digint ? asc_pkg::ASC_FE_DIGINT : asc_pkg::ASC_FE_RSVD);

	wire [4:0]  gap_a_w   = gap_en ? timing_a_q[`ASC_F_FINE] : 5'h00;
	wire [4:0]  gap_b_w   = gap_en ? timing_b_q[`ASC_F_FINE] : 5'h00;
	wire [9:0]  width_w   = 10'(timing_b_q[`ASC_F_WIDTH]) * 10'(CYC_PER_US);
	wire [10:0] coarse_w  = 11'(timing_b_q[`ASC_F_COARSE]) * 11'(CYC_PER_US);

	// Gain resolution per slot
	asc_gain_if gain_a_if ();
	asc_gain_if gain_b_if ();

	assign gain_a_if.ind_en = mode_a_q[`ASC_B_IND_EN];
	assign gain_a_if.common = mode_a_q[`ASC_F_COMMON_GAIN];
	assign gain_a_if.upper  = gain_pwr_q[`ASC_F_GAIN_A];
	assign gain_b_if.ind_en = mode_b_q[`ASC_B_IND_EN];
	assign gain_b_if.common = mode_b_q[`ASC_F_COMMON_GAIN];
	assign gain_b_if.upper  = gain_pwr_q[`ASC_F_GAIN_B];

	asc_gain_sel u_gain_a
	(
		.g (gain_a_if.sel)
	);

	asc_gain_sel u_gain_b
	(
		.g (gain_b_if.sel)
	);

	// Registered control outputs
	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			SLOTA_PATH        <= asc_pkg::ASC_PATH_FULL;
			SLOTB_MODE        <= asc_pkg::ASC_FE_NORMAL;
			SLOTA_INT_BUF     <= 1'b0;
			SLOTB_INT_BUF     <= 1'b0;
			SLOTA_GAIN        <= 8'h00;
			SLOTB_GAIN        <= 8'h00;
			SLOTA_DIGINT_EN   <= 1'b0;
			SLOTB_DIGINT_EN   <= 1'b0;
			SLOTA_UPPER_PD    <= 1'b0;
			SLOTB_UPPER_PD    <= 1'b0;
			SLOTA_GAP_US      <= 5'h00;
			SLOTB_GAP_US      <= 5'h00;
			SLOTA_SINGLE_PAIR <= 1'b0;
			SLOTB_SINGLE_PAIR <= 1'b0;
			SLOTB_WIDTH_CYC   <= 10'h050;
			SLOTB_OFFSET_CYC  <= 11'h1CC;
			SLOTB_FINE_OFFSET <= 5'h1C;
		end
		else
		begin
			SLOTA_PATH        <= path_a_w;
			SLOTB_MODE        <= fe_b_w;
			SLOTA_INT_BUF     <= buf_a;
			SLOTB_INT_BUF     <= buf_b;
			SLOTA_GAIN        <= gain_a_if.gain;
			SLOTB_GAIN        <= gain_b_if.gain;
			SLOTA_DIGINT_EN   <= dig_a;
			SLOTB_DIGINT_EN   <= dig_b;
			SLOTA_UPPER_PD    <= pd_all & dig_a;
			SLOTB_UPPER_PD    <= pd_all & dig_b;
			SLOTA_GAP_US      <= gap_a_w;
			SLOTB_GAP_US      <= gap_b_w;
			SLOTA_SINGLE_PAIR <= dig_opt_q[`ASC_B_PAIR_A];
			SLOTB_SINGLE_PAIR <= dig_opt_q[`ASC_B_PAIR_B];
			SLOTB_WIDTH_CYC   <= width_w;
			SLOTB_OFFSET_CYC  <= coarse_w;
			SLOTB_FINE_OFFSET <= timing_b_q[`ASC_F_FINE];
		end
	end

	// Checks
	path_full_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(REG_WE && sel_path_a && REG_WDATA == `ASC_CODE_FULL) |=> ##1 SLOTA_PATH == asc_pkg::ASC_PATH_FULL)
		else $error("slot A full path code not decoded");

	path_tia_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(path_a_q == `ASC_CODE_TIA_NOBUF && !mode_a_q[`ASC_B_BUF] && !mode_a_digint)
		|=> SLOTA_PATH == asc_pkg::ASC_PATH_TIA_ADC)
		else $error("slot A converter path without buffer not decoded");

	path_tia_buf_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(path_a_q == `ASC_CODE_TIA_BUF && (mode_a_q[`ASC_B_BUF] || mode_a_digint))
		|=> SLOTA_PATH == asc_pkg::ASC_PATH_TIA_ADC)
		else $error("slot A converter path with buffer not decoded");

	upper_pd_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(gain_pwr_q[`ASC_F_PD] == 3'h0) |=> !SLOTA_UPPER_PD && !SLOTB_UPPER_PD)
		else $error("channels powered down with power field zero");

	upper_pd_on_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(gain_pwr_q[`ASC_F_PD] == `ASC_PD_ALL && dig_b)
		|=> SLOTB_UPPER_PD)
		else $error("slot B upper channels not powered down");

	gain_ind_b_a: assert property (@(posedge CLK) disable iff (!RST_N)
		mode_b_q[`ASC_B_IND_EN] |=> SLOTB_GAIN[7:2] == $past(gain_pwr_q[11:6])
			&& SLOTB_GAIN[1:0] == $past(mode_b_q[1:0]))
		else $error("slot B individual gains not taken from shared register");

	gain_ind_a_a: assert property (@(posedge CLK) disable iff (!RST_N)
		mode_a_q[`ASC_B_IND_EN] |=> SLOTA_GAIN[7:2] == $past(gain_pwr_q[5:0])
			&& SLOTA_GAIN[1:0] == $past(mode_a_q[1:0]))
		else $error("slot A individual gains not taken from shared register");

	gain_common_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!mode_a_q[`ASC_B_IND_EN] |=> SLOTA_GAIN == {4{$past(mode_a_q[1:0])}})
		else $error("slot A common gain not applied to all channels");

	gain_common_b_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!mode_b_q[`ASC_B_IND_EN] |=> SLOTB_GAIN == {4{$past(mode_b_q[1:0])}})
		else $error("slot B common gain not applied to all channels");

	gap_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!gap_en |=> SLOTA_GAP_US == 5'h00 && SLOTB_GAP_US == 5'h00)
		else $error("gap present with gapped mode off");

	gap_on_a: assert property (@(posedge CLK) disable iff (!RST_N)
		gap_en |=> SLOTA_GAP_US == $past(timing_a_q[4:0])
			&& SLOTB_GAP_US == $past(timing_b_q[4:0]))
		else $error("gap not taken from fine offsets");

	pair_mode_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(REG_WE && sel_dig_opt) |=> ##1 SLOTB_SINGLE_PAIR == $past(REG_WDATA[6], 2)
			&& SLOTA_SINGLE_PAIR == $past(REG_WDATA[5], 2))
		else $error("pair mode bits not reflected");

	window_width_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(REG_WE && sel_timing_b && REG_WDATA[15:11] == 5'h01) |=> ##1 SLOTB_WIDTH_CYC == 10'h014)
		else $error("window width step not twenty cycles");

	coarse_fine_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(REG_WE && sel_timing_b) |=> ##1 SLOTB_FINE_OFFSET == $past(REG_WDATA[4:0], 2)
			&& SLOTB_OFFSET_CYC == 11'($past(REG_WDATA[10:5], 2)) * 11'h014)
		else $error("slot B offsets not reflected");

	mode_normal_a: assert property (@(posedge CLK) disable iff (!RST_N)
		mode_b_normal |=> SLOTB_MODE == asc_pkg::ASC_FE_NORMAL)
		else $error("slot B normal mode not decoded");

	digint_buf_a: assert property (@(posedge CLK) disable iff (!RST_N)
		mode_b_digint |=> SLOTB_INT_BUF && SLOTB_MODE == asc_pkg::ASC_FE_DIGINT)
		else $error("digital integrate mode did not force buffer");

	buf_plain_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(!mode_b_q[`ASC_B_BUF] && !mode_b_digint)
		|=> !SLOTB_INT_BUF)
		else $error("slot B integrator buffered without request");

	dig_enable_a: assert property (@(posedge CLK) disable iff (!RST_N)
		(REG_WE && sel_dig_en) |=> ##1 SLOTB_DIGINT_EN == $past(REG_WDATA[13], 2)
			&& SLOTA_DIGINT_EN == $past(REG_WDATA[12], 2))
		else $error("digital integration enables not reflected");

	read_back_a: assert property (@(posedge CLK) disable iff (!RST_N)
		REG_RE |=> REG_RVALID && REG_RDATA == $past(rd_mux))
		else $error("read data not returned one cycle after request");

	rvalid_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
		!REG_RE |=> !REG_RVALID)
		else $error("read valid without a read request");

endmodule : asc_slot_regs

/* File: tb/asc_slot_regs_test.sv */
// Self-checking bench for the slot configuration register bank
`timescale 1ns/1ps
module asc_slot_regs_test;
	typedef struct
	{
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic [15:0] rexp;
	} asc_row_t;

	logic        clk;
	logic        rst_n;
	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        we;
	logic        re;
	logic [15:0] rdata;
	logic        rvalid;
	logic [2:0]  a_path;
	logic [2:0]  b_mode;
	logic        a_buf;
	logic        b_buf;
	logic [7:0]  a_gain;
	logic [7:0]  b_gain;
	logic        a_dig;
	logic        b_dig;
	logic        a_pd;
	logic        b_pd;
	logic [4:0]  a_gap;
	logic [4:0]  b_gap;
	logic        a_single;
	logic        b_single;
	logic [9:0]  b_width;
	logic [10:0] b_offset;
	logic [4:0]  b_fine;
	int          num_errors;
	int          samples_checked;
	asc_row_t    rows [8];

	asc_slot_regs i_dut
	(
		.CLK               (clk),
		.RST_N             (rst_n),
		.REG_ADDR          (addr),
		.REG_WDATA         (wdata),
		.REG_WE            (we),
		.REG_RE            (re),
		.REG_RDATA         (rdata),
		.REG_RVALID        (rvalid),
		.SLOTA_PATH        (a_path),
		.SLOTB_MODE        (b_mode),
		.SLOTA_INT_BUF     (a_buf),
		.SLOTB_INT_BUF     (b_buf),
		.SLOTA_GAIN        (a_gain),
		.SLOTB_GAIN        (b_gain),
		.SLOTA_DIGINT_EN   (a_dig),
		.SLOTB_DIGINT_EN   (b_dig),
		.SLOTA_UPPER_PD    (a_pd),
		.SLOTB_UPPER_PD    (b_pd),
		.SLOTA_GAP_US      (a_gap),
		.SLOTB_GAP_US      (b_gap),
		.SLOTA_SINGLE_PAIR (a_single),
		.SLOTB_SINGLE_PAIR (b_single),
		.SLOTB_WIDTH_CYC   (b_width),
		.SLOTB_OFFSET_CYC  (b_offset),
		.SLOTB_FINE_OFFSET (b_fine)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Write, then wait until the decoded outputs have followed
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk) #5;
		addr = a;
		wdata = d;
		we = 1'b1;
		@(posedge clk) #5;
		we = 1'b0;
		@(posedge clk) #5;
	endtask : wr

	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk) #5;
		addr = a;
		re = 1'b1;
		@(posedge clk) #5;
		re = 1'b0;
		chk(rvalid, 16'h0001);
		chk(rdata, exp);
		@(posedge clk) #5;
		chk(rvalid, 16'h0000);
	endtask : rd

	task finish_test;
		$display("errors %0d, comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	initial
	begin
		#300000;
		num_errors++;
		finish_test;
	end

	initial
	begin
		num_errors = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		we = 1'b0;
		re = 1'b0;
		rows = '{'{8'h3B, 16'hFFFF, 16'hFFFF}, '{8'h39, 16'h1234, 16'h1234}, '{8'h43, 16'hB065, 16'hB065},
			'{8'h44, 16'h1DC3, 16'h1DC3}, '{8'h55, 16'hFFFF, 16'hEFFF}, '{8'h58, 16'hFFFF, 16'h3000},
			'{8'h5A, 16'hFFFF, 16'h00E0}, '{8'h10, 16'hFFFF, 16'h0000}};
		repeat (10) @(posedge clk);
		#5;
		rst_n = 1'b1;
		// Readback of every register except slot A mode 0x42, plus unmapped 0x10, reserved bits masked
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].rexp);
		end
		// Slot A path codes
		wr(8'h42, 16'h1C00);
		wr(8'h43, 16'hB065);
		chk(a_path, 16'h0002);
		chk(a_buf, 16'h0000);
		wr(8'h43, 16'hAE65);
		chk(a_path, 16'h0004);
		wr(8'h42, 16'h1C80);
		chk(a_path, 16'h0002);
		chk(a_buf, 16'h0001);
		wr(8'h43, 16'hADA5);
		chk(a_path, 16'h0001);
		wr(8'h42, 16'h1D00);
		wr(8'h43, 16'hAE65);
		chk(a_path, 16'h0002);
		chk(a_buf, 16'h0001);
		// Slot B mode byte and buffer bit
		wr(8'h44, 16'h1C00);
		chk(b_mode, 16'h0001);
		chk(b_buf, 16'h0000);
		wr(8'h44, 16'h1C80);
		chk(b_buf, 16'h0001);
		wr(8'h44, 16'h1D00);
		chk(b_mode, 16'h0002);
		chk(b_buf, 16'h0001);
		wr(8'h44, 16'h2000);
		chk(b_mode, 16'h0004);
		// Common gain, then individual gains
		wr(8'h42, 16'h1C02);
		wr(8'h44, 16'h1C02);
		wr(8'h55, 16'h0E5B);
		chk(a_gain, 16'h00AA);
		chk(b_gain, 16'h00AA);
		wr(8'h44, 16'h1C41);
		chk(b_gain, 16'h00E5);
		wr(8'h42, 16'h1C42);
		chk(a_gain, 16'h006E);
		// Channel power-down and integration enables
		wr(8'h55, 16'hE000);
		wr(8'h58, 16'h2000);
		chk(b_dig, 16'h0001);
		chk(a_dig, 16'h0000);
		chk(b_pd, 16'h0001);
		chk(a_pd, 16'h0000);
		wr(8'h55, 16'h0000);
		chk(b_pd, 16'h0000);
		// Window timing, gap and pair modes
		wr(8'h3B, 16'h0800);
		chk(b_width, 16'h0014);
		chk(b_offset, 16'h0000);
		wr(8'h3B, 16'hFFE5);
		wr(8'h39, 16'h2289);
		chk(b_width, 16'h026C);
		chk(b_offset, 16'h04EC);
		chk(b_fine, 16'h0005);
		wr(8'h5A, 16'h0080);
		chk(b_gap, 16'h0005);
		chk(a_gap, 16'h0009);
		wr(8'h5A, 16'h0060);
		chk(b_gap, 16'h0000);
		chk(a_single, 16'h0001);
		chk(b_single, 16'h0001);
		wr(8'h5A, 16'h0040);
		chk(a_single, 16'h0000);
		// Second reset in mid-run
		@(posedge clk) #5;
		rst_n = 1'b0;
		#20;
		chk(a_path, 16'h0001);
		chk(b_width, 16'h0050);
		chk(b_offset, 16'h01CC);
		chk(b_fine, 16'h001C);
		chk(b_mode, 16'h0001);
		chk(a_gain, 16'h0000);
		chk(rvalid, 16'h0000);
		chk(rdata, 16'h0000);
		@(posedge clk) #5;
		rst_n = 1'b1;
		rd(8'h3B, 16'h22FC);
		rd(8'h43, 16'hADA5);
		rd(8'h55, 16'h0000);
		finish_test;
	end
endmodule : asc_slot_regs_test
